// ### rtl/dq_pkg.sv
package dq_pkg;
	localparam int unsigned PADDR_W = 16;
	localparam int unsigned PDATA_W = 32;
	localparam int unsigned REG_W   = 16;
	localparam int unsigned REG_N   = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [13:0] IDX_RELEASE_SLOPE = 14'h0442;
	localparam logic [13:0] IDX_COMP_KNEE     = 14'h0443;
	localparam logic [13:0] IDX_GATE_KNEE     = 14'h0444;
	localparam logic [13:0] IDX_GATE_CTRL     = 14'h0445;
	localparam logic [13:0] IDX_GAINS_FIRST   = 14'h0480;
	localparam logic [13:0] IDX_GAINS_SECOND  = 14'h0481;
	localparam logic [13:0] IDX_B1_COEF_A     = 14'h0482;
	localparam logic [13:0] IDX_B1_COEF_B     = 14'h0483;
	localparam logic [13:0] IDX_B1_COEF_PG    = 14'h0484;
	localparam logic [13:0] IDX_B2_COEF_A     = 14'h0485;

	// Slots in the register array.
	localparam int unsigned S_RELEASE = 0;
	localparam int unsigned S_KNEE    = 1;
	localparam int unsigned S_GATE    = 2;
	localparam int unsigned S_CTRL    = 3;
	localparam int unsigned S_GAINS1  = 4;
	localparam int unsigned S_GAINS2  = 5;
	localparam int unsigned S_B1A     = 6;
	localparam int unsigned S_B1B     = 7;
	localparam int unsigned S_B1PG    = 8;
	localparam int unsigned S_B2A     = 9;

	localparam logic [13:0] REG_IDX [REG_N] = '{IDX_RELEASE_SLOPE, IDX_COMP_KNEE,
		IDX_GATE_KNEE, IDX_GATE_CTRL, IDX_GAINS_FIRST, IDX_GAINS_SECOND,
		IDX_B1_COEF_A, IDX_B1_COEF_B, IDX_B1_COEF_PG, IDX_B2_COEF_A};
	localparam logic [15:0] REG_RST [REG_N] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h6318, 16'h6300, 16'h0fca, 16'h0400, 16'h00d8, 16'h1eb5};
	// Bits that hold storage; the others read as zero.
	localparam logic [15:0] REG_MASK [REG_N] = '{16'hffff, 16'h07ff, 16'h03ff, 16'h0003,
		16'hffff, 16'hffc1, 16'hffff, 16'hffff, 16'hffff, 16'hffff};

	// Field positions.
	localparam int unsigned QRD_LSB      = 6;
	localparam int unsigned UP_LSB       = 3;
	localparam int unsigned LO_LSB       = 0;
	localparam int unsigned KIN_LSB      = 5;
	localparam int unsigned KOUT_LSB     = 0;
	localparam int unsigned GIN_LSB      = 5;
	localparam int unsigned GOUT_LSB     = 0;
	localparam int unsigned GATE_EN_BIT  = 0;
	localparam int unsigned GOUT_EN_BIT  = 1;
	localparam int unsigned B1_LSB       = 11;
	localparam int unsigned B2_LSB       = 6;
	localparam int unsigned B3_LSB       = 1;
	localparam int unsigned B4_LSB       = 11;
	localparam int unsigned B5_LSB       = 6;
	localparam int unsigned EQ_ENA_BIT   = 0;
	localparam int unsigned SHAPE_BIT    = 0;
	localparam int unsigned GAIN_W       = 5;
	localparam int unsigned BANDS        = 5;

	// Codes and level steps, levels in quarter-dB of attenuation.
	localparam logic [1:0] QRD_RSVD       = 2'h3;
	localparam logic [2:0] UP_ZERO_CODE   = 3'h5;
	localparam logic [2:0] LO_ZERO_CODE   = 3'h4;
	localparam logic [5:0] KIN_MAX_CODE   = 6'h3c;
	localparam logic [4:0] KOUT_RSVD      = 5'h1f;
	localparam logic [7:0] KNEE_STEP_QDB  = 8'h03;
	localparam logic [8:0] GATE_STEP_QDB  = 9'h006;
	localparam logic [8:0] GIN_BASE_QDB   = 9'h090;
	localparam logic [8:0] GOUT_BASE_QDB  = 9'h078;
	localparam logic [4:0] GAIN_ZERO_CODE = 5'h0c;
	localparam logic [4:0] GAIN_MAX_CODE  = 5'h18;

	// Quick-release decay per 6dB.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned QRD0_NS       = 725000;
	localparam int unsigned QRD1_NS       = 1450000;
	localparam int unsigned QRD2_NS       = 5800000;
endpackage

// ### rtl/dq_gain_map.sv
`timescale 1ns/1ps
module dq_gain_map
	import dq_pkg::*;
(
	input  wire logic [REG_W-1:0]         gains_first,  // First gain word.
	input  wire logic [REG_W-1:0]         gains_second, // Second gain word.
	output logic      [BANDS-1:0][5:0]    gain_db,      // Signed dB per band, 0 if bypassed.
	output logic                          gain_rsvd     // Some band holds a reserved code.
);
	logic [BANDS-1:0][GAIN_W-1:0] code;
	logic [BANDS-1:0]             rsvd;

	assign code[0] = gains_first[B1_LSB +: GAIN_W];
	assign code[1] = gains_first[B2_LSB +: GAIN_W];
	assign code[2] = gains_first[B3_LSB +: GAIN_W];
	assign code[3] = gains_second[B4_LSB +: GAIN_W];
	assign code[4] = gains_second[B5_LSB +: GAIN_W];

	genvar b;
	generate
		for (b = 0; b < BANDS; b++) begin : g_band
			// Code 12 is flat; a bypassed equaliser shows flat on every band.
			assign gain_db[b] = gains_first[EQ_ENA_BIT] ?
				6'({1'b0, code[b]} - {1'b0, GAIN_ZERO_CODE}) : 6'h00;
			assign rsvd[b] = code[b] > GAIN_MAX_CODE;
		end
	endgenerate

	assign gain_rsvd = |rsvd;
endmodule

// ### rtl/dq_drc_map.sv
`timescale 1ns/1ps
module dq_drc_map
	import dq_pkg::*;
#(
	parameter int unsigned CNT_W    = 20,
	parameter int unsigned QRD0_CYC = 72500,
	parameter int unsigned QRD1_CYC = 145000,
	parameter int unsigned QRD2_CYC = 580000
)(
	input  wire logic [REG_W-1:0] release_word, // Decay and slope word.
	input  wire logic [REG_W-1:0] knee_word,    // Compressor knee word.
	input  wire logic [REG_W-1:0] gate_word,    // Gate knee word.
	input  wire logic [REG_W-1:0] ctrl_word,    // Gate enables word.
	output logic      [CNT_W-1:0] decay_cyc,    // Quick-release cycles per 6dB.
	output logic      [2:0]       up_shift,     // Upper slope as a right shift.
	output logic                  up_zero,      // Upper slope is flat zero.
	output logic      [2:0]       lo_shift,     // Lower slope as a right shift.
	output logic                  lo_zero,      // Lower slope is flat zero.
	output logic      [7:0]       kin_qdb,      // Knee input attenuation.
	output logic      [7:0]       kout_qdb,     // Knee output attenuation.
	output logic      [8:0]       gin_qdb,      // Applied gate input threshold.
	output logic                  gin_valid,    // Gate input threshold in use.
	output logic      [8:0]       gout_qdb,     // Applied gate output level.
	output logic                  gout_valid,   // Gate output level in use.
	output logic                  drc_rsvd      // Some field holds a reserved code.
);
	logic [1:0] qrd;
	logic [2:0] up;
	logic [2:0] lo;
	logic [5:0] kin;
	logic [4:0] kout;
	logic [4:0] gin;
	logic [4:0] gout;

	assign qrd  = release_word[QRD_LSB +: 2];
	assign up   = release_word[UP_LSB +: 3];
	assign lo   = release_word[LO_LSB +: 3];
	assign kin  = knee_word[KIN_LSB +: 6];
	assign kout = knee_word[KOUT_LSB +: 5];
	assign gin  = gate_word[GIN_LSB +: 5];
	assign gout = gate_word[GOUT_LSB +: 5];

	always_comb begin
		case (qrd)
			2'h0:    decay_cyc = CNT_W'(QRD0_CYC);
			2'h1:    decay_cyc = CNT_W'(QRD1_CYC);
			2'h2:    decay_cyc = CNT_W'(QRD2_CYC);
			default: decay_cyc = CNT_W'(QRD2_CYC);
		endcase
	end

	assign up_zero  = up == UP_ZERO_CODE;
	assign up_shift = up_zero ? 3'h0 : up;
	assign lo_zero  = lo == LO_ZERO_CODE;
	assign lo_shift = lo_zero ? 3'h0 : lo;
	assign kin_qdb  = 8'(kin) * KNEE_STEP_QDB;
	assign kout_qdb = 8'(kout) * KNEE_STEP_QDB;
	assign gin_valid  = ctrl_word[GATE_EN_BIT];
	assign gin_qdb    = gin_valid ? GIN_BASE_QDB + 9'(gin) * GATE_STEP_QDB : 9'h000;
	assign gout_valid = ctrl_word[GOUT_EN_BIT];
	assign gout_qdb   = gout_valid ? GOUT_BASE_QDB + 9'(gout) * GATE_STEP_QDB : 9'h000;

	// Reserved codes are still stored; they are only flagged here.
	assign drc_rsvd = (qrd == QRD_RSVD) || (up > UP_ZERO_CODE) || (lo > LO_ZERO_CODE) ||
		(kin > KIN_MAX_CODE) || (kout == KOUT_RSVD);
endmodule

// ### rtl/dq_regs.sv
// How it works
// - Quick-release decay codes 0, 1 and 2 give 0.725ms, 1.45ms and 5.8ms per 6dB, code 3 is reserved, reset 0.
// - The upper slope at bits 5:3 gives 1, 1/2, 1/4, 1/8, 1/16 and 0 for codes 0 to 5, reset 0.
// - The lower slope at bits 2:0 gives 1, 1/2, 1/4, 1/8 and 0 for codes 0 to 4, reset 0.
// - The knee input level at bits 10:5 falls 0.75dB per code from 0dB to -45dB at code 60.
// - The knee output level at bits 4:0 falls 0.75dB per code from 0dB to -22.5dB at code 30.
// - The gate knee input level at bits 9:5 falls 1.5dB per code from -36dB to -82.5dB.
// - The gate knee input level is applied only while the gate enable is set.
// - The gate knee output level at bits 4:0 falls 1.5dB per code from -30dB to -76.5dB.
// - The gate knee output level is used only while the gate knee output enable is set.
// - Each of the five band gains is five bits for -12dB to +12dB in 1dB steps, reset 12.
// - Bit 0 of the first gain word puts the equaliser in the path, reset bypassed.
// - The coefficient words are full 16-bit registers each with its own non-zero reset.
`timescale 1ns/1ps
module dq_regs
	import dq_pkg::*;
#(
	parameter int unsigned DECAY_CNT_W = 20,
	parameter int unsigned QRD0_CYC    = QRD0_NS / CLK_PERIOD_NS,
	parameter int unsigned QRD1_CYC    = QRD1_NS / CLK_PERIOD_NS,
	parameter int unsigned QRD2_CYC    = QRD2_NS / CLK_PERIOD_NS
)(
	input  wire logic                   pclk,                 // Register clock.
	input  wire logic                   presetn,              // Asynchronous reset, low.
	input  wire logic                   psel,                 // APB select.
	input  wire logic                   penable,              // APB access phase.
	input  wire logic                   pwrite,               // APB write.
	input  wire logic [PADDR_W-1:0]     paddr,                // APB byte address.
	input  wire logic [PDATA_W-1:0]     pwdata,               // APB write data.
	input  wire logic [3:0]             pstrb,                // APB byte strobes.
	output logic      [PDATA_W-1:0]     prdata,               // APB read data.
	output logic                        pready,               // APB ready.
	output logic                        pslverr,              // APB error.
	output logic      [1:0]             quick_release_decay,  // Decay code.
	output logic      [DECAY_CNT_W-1:0] qr_decay_cycles,      // Decay cycles per 6dB.
	output logic      [2:0]             upper_slope,          // Upper slope code.
	output logic      [2:0]             upper_slope_shift,    // Upper slope shift.
	output logic                        upper_slope_zero,     // Upper slope is zero.
	output logic      [2:0]             lower_slope,          // Lower slope code.
	output logic      [2:0]             lower_slope_shift,    // Lower slope shift.
	output logic                        lower_slope_zero,     // Lower slope is zero.
	output logic      [5:0]             knee_in_level,        // Knee input code.
	output logic      [7:0]             knee_in_atten_qdb,    // Knee input in quarter-dB.
	output logic      [4:0]             knee_out_level,       // Knee output code.
	output logic      [7:0]             knee_out_atten_qdb,   // Knee output in quarter-dB.
	output logic                        gate_enable,          // Gate enable.
	output logic                        gate_knee_out_enable, // Gate output knee enable.
	output logic      [4:0]             gate_knee_in_level,   // Gate input code.
	output logic      [8:0]             gate_in_atten_qdb,    // Applied gate input level.
	output logic                        gate_in_valid,        // Gate input level in use.
	output logic      [4:0]             gate_knee_out_level,  // Gate output code.
	output logic      [8:0]             gate_out_atten_qdb,   // Applied gate output level.
	output logic                        gate_out_valid,       // Gate output level in use.
	output logic                        equaliser_enable,     // Equaliser in path.
	output logic                        band_one_filter_shape,// 0 shelving, 1 peak.
	output logic      [GAIN_W-1:0]      band_one_gain,        // Band one gain code.
	output logic      [GAIN_W-1:0]      band_two_gain,        // Band two gain code.
	output logic      [GAIN_W-1:0]      band_three_gain,      // Band three gain code.
	output logic      [GAIN_W-1:0]      band_four_gain,       // Band four gain code.
	output logic      [GAIN_W-1:0]      band_five_gain,       // Band five gain code.
	output logic      [BANDS-1:0][5:0]  band_gain_db,         // Applied signed gains.
	output logic      [REG_W-1:0]       band_one_coef_a,      // Band one coefficient A.
	output logic      [REG_W-1:0]       band_one_coef_b,      // Band one coefficient B.
	output logic      [REG_W-1:0]       band_one_coef_pg,     // Band one coefficient PG.
	output logic      [REG_W-1:0]       band_two_coef_a,      // Band two coefficient A.
	output logic                        reserved_code,        // Some field is reserved.
	output logic      [REG_N-1:0]       reg_written           // Pulse per written register.
);
	// A decay count that does not fit the counter width would wrap without notice.
	generate
		if (DECAY_CNT_W < 1) begin : g_bad_width
			$error("Decay width must be at least one bit");
		end
		if (QRD0_CYC < 1 || QRD0_CYC > QRD1_CYC || QRD1_CYC > QRD2_CYC) begin : g_bad_order
			$error("Decay counts must be non-zero and increasing");
		end
		if (QRD2_CYC >= (64'h1 << DECAY_CNT_W)) begin : g_bad_fit
			$error("Decay counts do not fit the decay width");
		end
	endgenerate

	typedef struct packed {
		logic [REG_N-1:0][REG_W-1:0] regs;
		logic [PDATA_W-1:0]          rdata;
		logic [REG_N-1:0]            written;
		logic [DECAY_CNT_W-1:0]      decay_cyc;
		logic [2:0]                  up_shift;
		logic                        up_zero;
		logic [2:0]                  lo_shift;
		logic                        lo_zero;
		logic [7:0]                  kin_qdb;
		logic [7:0]                  kout_qdb;
		logic [8:0]                  gin_qdb;
		logic                        gin_valid;
		logic [8:0]                  gout_qdb;
		logic                        gout_valid;
		logic [BANDS-1:0][5:0]       gain_db;
		logic                        rsvd;
	} dq_state_s;

	dq_state_s state_reg;
	dq_state_s state_next;

	logic [DECAY_CNT_W-1:0] m_decay;
	logic [2:0]             m_up_shift;
	logic                   m_up_zero;
	logic [2:0]             m_lo_shift;
	logic                   m_lo_zero;
	logic [7:0]             m_kin;
	logic [7:0]             m_kout;
	logic [8:0]             m_gin;
	logic                   m_gin_valid;
	logic [8:0]             m_gout;
	logic                   m_gout_valid;
	logic                   m_drc_rsvd;
	logic [BANDS-1:0][5:0]  m_gain_db;
	logic                   m_gain_rsvd;
	logic [REG_N-1:0]       hit;
	logic                   hit_any;
	logic [REG_W-1:0]       rd_word;
	logic [REG_W-1:0]       lane_mask;
	logic                   misaligned;
	logic                   unmapped;
	logic                   wr_access;
	logic                   rd_setup;
	logic [REG_W-1:0]       wr_word;

	// Mapping works on the stored words, so derived outputs trail a write by one cycle.
	dq_drc_map #(
		.CNT_W    (DECAY_CNT_W),
		.QRD0_CYC (QRD0_CYC),
		.QRD1_CYC (QRD1_CYC),
		.QRD2_CYC (QRD2_CYC)
	) u_drc_map (
		.release_word (state_reg.regs[S_RELEASE]),
		.knee_word    (state_reg.regs[S_KNEE]),
		.gate_word    (state_reg.regs[S_GATE]),
		.ctrl_word    (state_reg.regs[S_CTRL]),
		.decay_cyc    (m_decay),
		.up_shift     (m_up_shift),
		.up_zero      (m_up_zero),
		.lo_shift     (m_lo_shift),
		.lo_zero      (m_lo_zero),
		.kin_qdb      (m_kin),
		.kout_qdb     (m_kout),
		.gin_qdb      (m_gin),
		.gin_valid    (m_gin_valid),
		.gout_qdb     (m_gout),
		.gout_valid   (m_gout_valid),
		.drc_rsvd     (m_drc_rsvd)
	);

	dq_gain_map u_gain_map (
		.gains_first  (state_reg.regs[S_GAINS1]),
		.gains_second (state_reg.regs[S_GAINS2]),
		.gain_db      (m_gain_db),
		.gain_rsvd    (m_gain_rsvd)
	);

	// An address off a word boundary is refused even if its word index is mapped.
	assign misaligned = paddr[1:0] != 2'h0;

	genvar gi;
	generate
		for (gi = 0; gi < REG_N; gi++) begin : g_dec
			assign hit[gi] = (paddr[PADDR_W-1:2] == REG_IDX[gi]) && !misaligned;
		end
	endgenerate

	assign hit_any   = |hit;
	assign unmapped  = !hit_any;
	// Strobes 3 and 2 cover bits that no register stores.
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	// Lanes whose strobe is low keep their stored bits.
	assign wr_word   = pwdata[REG_W-1:0] & lane_mask;
	// A write lands only at the edge that closes the access phase.
	assign wr_access = psel && penable && pwrite;
	assign rd_setup  = psel && !penable;

	always_comb begin
		rd_word = '0;
		for (int i = 0; i < REG_N; i++) begin
			if (hit[i]) begin
				rd_word = rd_word | state_reg.regs[i];
			end
		end
	end

	always_comb begin
		state_next         = state_reg;
		state_next.written = '0;
		// Read data is captured in the setup cycle so it stands through the access phase.
		if (rd_setup) begin
			state_next.rdata = {{(PDATA_W-REG_W){1'b0}}, rd_word};
		end
		if (wr_access) begin
			for (int i = 0; i < REG_N; i++) begin
				if (hit[i]) begin
					// Reserved codes are stored as written.
					state_next.regs[i] = ((state_reg.regs[i] & ~lane_mask) |
						wr_word) & REG_MASK[i];
					state_next.written[i] = |lane_mask;
				end
			end
		end
		state_next.decay_cyc  = m_decay;
		state_next.up_shift   = m_up_shift;
		state_next.up_zero    = m_up_zero;
		state_next.lo_shift   = m_lo_shift;
		state_next.lo_zero    = m_lo_zero;
		state_next.kin_qdb    = m_kin;
		state_next.kout_qdb   = m_kout;
		state_next.gin_qdb    = m_gin;
		state_next.gin_valid  = m_gin_valid;
		state_next.gout_qdb   = m_gout;
		state_next.gout_valid = m_gout_valid;
		state_next.gain_db    = m_gain_db;
		state_next.rsvd       = m_drc_rsvd | m_gain_rsvd;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < REG_N; i++) begin
				state_reg.regs[i] <= REG_RST[i];
			end
			// Derived outputs reset to what the reset field values map to.
			state_reg.rdata      <= '0;
			state_reg.written    <= '0;
			state_reg.decay_cyc  <= DECAY_CNT_W'(QRD0_CYC);
			state_reg.up_shift   <= '0;
			state_reg.up_zero    <= 1'b0;
			state_reg.lo_shift   <= '0;
			state_reg.lo_zero    <= 1'b0;
			state_reg.kin_qdb    <= '0;
			state_reg.kout_qdb   <= '0;
			state_reg.gin_qdb    <= '0;
			state_reg.gin_valid  <= 1'b0;
			state_reg.gout_qdb   <= '0;
			state_reg.gout_valid <= 1'b0;
			state_reg.gain_db    <= '0;
			state_reg.rsvd       <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// The bank never stalls, so every access phase completes at once.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && unmapped;
	assign prdata  = state_reg.rdata;

	assign quick_release_decay   = state_reg.regs[S_RELEASE][QRD_LSB +: 2];
	assign upper_slope           = state_reg.regs[S_RELEASE][UP_LSB +: 3];
	assign lower_slope           = state_reg.regs[S_RELEASE][LO_LSB +: 3];
	assign knee_in_level         = state_reg.regs[S_KNEE][KIN_LSB +: 6];
	assign knee_out_level        = state_reg.regs[S_KNEE][KOUT_LSB +: 5];
	assign gate_knee_in_level    = state_reg.regs[S_GATE][GIN_LSB +: 5];
	assign gate_knee_out_level   = state_reg.regs[S_GATE][GOUT_LSB +: 5];
	assign gate_enable           = state_reg.regs[S_CTRL][GATE_EN_BIT];
	assign gate_knee_out_enable  = state_reg.regs[S_CTRL][GOUT_EN_BIT];

	assign equaliser_enable      = state_reg.regs[S_GAINS1][EQ_ENA_BIT];
	assign band_one_filter_shape = state_reg.regs[S_GAINS2][SHAPE_BIT];
	assign band_one_gain         = state_reg.regs[S_GAINS1][B1_LSB +: GAIN_W];
	assign band_two_gain         = state_reg.regs[S_GAINS1][B2_LSB +: GAIN_W];
	assign band_three_gain       = state_reg.regs[S_GAINS1][B3_LSB +: GAIN_W];
	assign band_four_gain        = state_reg.regs[S_GAINS2][B4_LSB +: GAIN_W];
	assign band_five_gain        = state_reg.regs[S_GAINS2][B5_LSB +: GAIN_W];

	assign band_one_coef_a       = state_reg.regs[S_B1A];
	assign band_one_coef_b       = state_reg.regs[S_B1B];
	assign band_one_coef_pg      = state_reg.regs[S_B1PG];
	assign band_two_coef_a       = state_reg.regs[S_B2A];

	assign qr_decay_cycles    = state_reg.decay_cyc;
	assign upper_slope_shift  = state_reg.up_shift;
	assign upper_slope_zero   = state_reg.up_zero;
	assign lower_slope_shift  = state_reg.lo_shift;
	assign lower_slope_zero   = state_reg.lo_zero;
	assign knee_in_atten_qdb  = state_reg.kin_qdb;
	assign knee_out_atten_qdb = state_reg.kout_qdb;
	assign gate_in_atten_qdb  = state_reg.gin_qdb;
	assign gate_in_valid      = state_reg.gin_valid;
	assign gate_out_atten_qdb = state_reg.gout_qdb;
	assign gate_out_valid     = state_reg.gout_valid;
	assign band_gain_db       = state_reg.gain_db;
	assign reserved_code      = state_reg.rsvd;
	assign reg_written        = state_reg.written;
endmodule

// ### dv/dq_regs_assertions.sv
`timescale 1ns/1ps
module dq_regs_checker
	import dq_pkg::*;
#(
	parameter int unsigned DECAY_CNT_W = 20,
	parameter int unsigned QRD0_CYC    = 72500
)(
	input wire logic                   pclk, presetn, psel, penable, pwrite,
	input wire logic [PADDR_W-1:0]     paddr,
	input wire logic [3:0]             pstrb,
	input wire logic [PDATA_W-1:0]     prdata,
	input wire logic                   pslverr, upper_slope_zero, gate_enable, equaliser_enable,
	input wire logic [1:0]             quick_release_decay,
	input wire logic [DECAY_CNT_W-1:0] qr_decay_cycles,
	input wire logic [2:0]             upper_slope,
	input wire logic [8:0]             gate_in_atten_qdb,
	input wire logic [BANDS-1:0][5:0]  band_gain_db,
	input wire logic [REG_N-1:0]       reg_written
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_read_setup; psel && !penable && !pwrite; endsequence
	sequence s_access; psel && penable; endsequence
	logic decay_wr;
	assign decay_wr = psel && penable && pwrite && paddr == 16'h1108 && pstrb[0];
	sequence s_decay_write; s_access and decay_wr; endsequence
	AST_READ_UPPER: assert property (s_read_setup ##1 s_access |-> prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_WRITE_PULSE: assert property (s_decay_write |=> reg_written[0])
		else $error("no write pulse for decay register");
	AST_DECAY_HOLD: assert property (!decay_wr |=> $stable(quick_release_decay))
		else $error("decay field changed without a write");
	// Derived outputs follow the raw field one edge later.
	AST_DECAY0: assert property (quick_release_decay == 2'h0 |=> qr_decay_cycles == QRD0_CYC)
		else $error("decay code 0 gives wrong cycle count");
	AST_UPPER_ZERO: assert property (upper_slope == 3'h5 |=> upper_slope_zero)
		else $error("upper slope code 5 not flat");
	AST_GATE_OFF: assert property (!gate_enable |=> gate_in_atten_qdb == 9'h000)
		else $error("gate threshold applied while gate disabled");
	AST_EQ_BYPASS: assert property (!equaliser_enable |=> band_gain_db == '0)
		else $error("band gains applied while bypassed");
	AST_MISALIGNED: assert property ((s_access and (paddr[1:0] != 2'h0)) |-> pslverr)
		else $error("misaligned access not refused");
endmodule
bind dq_regs dq_regs_checker #(.DECAY_CNT_W(DECAY_CNT_W), .QRD0_CYC(QRD0_CYC)) dq_regs_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
	.upper_slope_zero(upper_slope_zero), .gate_enable(gate_enable),
	.equaliser_enable(equaliser_enable), .quick_release_decay(quick_release_decay),
	.qr_decay_cycles(qr_decay_cycles), .upper_slope(upper_slope),
	.gate_in_atten_qdb(gate_in_atten_qdb), .band_gain_db(band_gain_db), .reg_written(reg_written));

// ### dv/tb.sv
`timescale 1ns/1ps
module tb
	import dq_pkg::*;
;
	logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0]           paddr = 16'h0000;
	logic [31:0]           pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0]            pstrb = 4'h0;
	logic                  pready, pslverr, upper_slope_zero, reserved_code, er;
	logic                  lower_slope_zero, band_one_filter_shape;
	logic [7:0]            knee_in_atten_qdb, knee_out_atten_qdb;
	logic [4:0]            band_one_gain;
	logic [19:0]           qr_decay_cycles;
	logic [8:0]            gate_in_atten_qdb, gate_out_atten_qdb;
	logic [BANDS-1:0][5:0] band_gain_db;
	int                    n_errors = 0, checks = 0;
	always #5 pclk = ~pclk;
	dq_regs #(.QRD0_CYC(5), .QRD1_CYC(10), .QRD2_CYC(40)) dq_regs_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .quick_release_decay(), .qr_decay_cycles(qr_decay_cycles),
		.upper_slope(), .upper_slope_shift(), .upper_slope_zero(upper_slope_zero),
		.lower_slope(), .lower_slope_shift(), .lower_slope_zero(lower_slope_zero),
		.knee_in_level(), .knee_in_atten_qdb(knee_in_atten_qdb), .knee_out_level(),
		.knee_out_atten_qdb(knee_out_atten_qdb), .gate_enable(),
		.gate_knee_out_enable(), .gate_knee_in_level(), .gate_in_atten_qdb(gate_in_atten_qdb),
		.gate_in_valid(), .gate_knee_out_level(), .gate_out_atten_qdb(gate_out_atten_qdb),
		.gate_out_valid(), .equaliser_enable(), .band_one_filter_shape(band_one_filter_shape),
		.band_one_gain(band_one_gain),
		.band_two_gain(), .band_three_gain(), .band_four_gain(), .band_five_gain(),
		.band_gain_db(band_gain_db), .band_one_coef_a(), .band_one_coef_b(),
		.band_one_coef_pg(), .band_two_coef_a(), .reserved_code(reserved_code), .reg_written());
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request is held until pready is seen high; a hang is cut by the watchdog.
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task t_regs;
		for (int i = 0; i < REG_N; i++) begin
			apb(1'b0, {REG_IDX[i], 2'b00}, 32'h0, 4'h0);
			chk(rd, {16'h0000, REG_RST[i]});
			apb(1'b1, {REG_IDX[i], 2'b00}, 32'hffff_ffff, 4'hf);
			apb(1'b0, {REG_IDX[i], 2'b00}, 32'h0, 4'h0);
			chk(rd, {16'h0000, REG_MASK[i]});
		end
		chk(reserved_code, 1'b1);
	endtask
	task t_decay;
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, 16'h1108, {24'h00_0000, c[1:0], 6'h28}, 4'h1);
			repeat (2) @(posedge pclk);
			chk(qr_decay_cycles, c == 2 ? 32'd40 : 32'd5 << c);
			chk(upper_slope_zero, 1'b1);
		end
	endtask
	task t_gate;
		apb(1'b1, 16'h1114, 32'h2, 4'h1);
		repeat (2) @(posedge pclk);
		chk(gate_in_atten_qdb, 9'h000);
		chk(gate_out_atten_qdb, 9'h132);
		apb(1'b1, 16'h1114, 32'h1, 4'h1);
		repeat (2) @(posedge pclk);
		chk(gate_in_atten_qdb, 9'h14a);
		chk(gate_out_atten_qdb, 9'h000);
	endtask
	task t_eq;
		apb(1'b1, 16'h1200, 32'h0000_c019, 4'h3);
		repeat (2) @(posedge pclk);
		chk(band_gain_db[0], 6'h0c);
		chk(band_gain_db[1], 6'h34);
		chk(band_gain_db[2], 6'h00);
	endtask
	task t_knee;
		apb(1'b1, 16'h1108, 32'h0000_0004, 4'h1);
		apb(1'b1, 16'h110c, 32'h0000_079e, 4'h3);
		repeat (2) @(posedge pclk);
		chk(lower_slope_zero, 1'b1);
		chk(knee_in_atten_qdb, 8'hb4);
		chk(knee_out_atten_qdb, 8'h5a);
	endtask
	task t_bypass;
		apb(1'b1, 16'h1200, 32'h0000_0018, 4'h1);
		apb(1'b1, 16'h1204, 32'h0000_0001, 4'h1);
		repeat (2) @(posedge pclk);
		chk(band_gain_db, 32'h0);
		chk(band_one_gain, 5'h18);
		chk(band_one_filter_shape, 1'b1);
	endtask
	task t_bus;
		apb(1'b0, 16'h1109, 32'h0, 4'h0);
		chk(rd, 32'h0);
		chk(er, 1'b1);
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_decay();
		t_gate();
		t_eq();
		t_knee();
		t_bypass();
		t_bus();
		tally_and_finish();
	end
	initial begin
		#50000;
		n_errors++;
		tally_and_finish();
	end
endmodule
